//--- src/core_regs_pkg.sv
// Purpose: Shared constants for the core dedicated register block
// Assumes: 4-bit register index on the plain register port
// Notes:   CONDITION_CODE_BYTE bit positions and region limits are held here only
package core_regs_pkg;
  // Register indices on the software port
  localparam logic [3:0] OFF_INSTR_PTR  = 4'h0;
  localparam logic [3:0] OFF_ACCUM      = 4'h1;
  localparam logic [3:0] OFF_TEMP_ACCUM = 4'h2;
  localparam logic [3:0] OFF_INDEX_PTR  = 4'h3;
  localparam logic [3:0] OFF_EXTRA_PTR  = 4'h4;
  localparam logic [3:0] OFF_STACK_PTR  = 4'h5;
  localparam logic [3:0] OFF_PSW        = 4'h6;
  localparam logic [3:0] OFF_ALU_CMD    = 4'h7;
  localparam logic [3:0] OFF_GPR_SEL    = 4'h8;
  localparam logic [3:0] OFF_GPR_ADDR   = 4'h9;
  localparam logic [3:0] OFF_PROBE      = 4'hA;
  localparam logic [3:0] OFF_REGION     = 4'hB;

  // Condition code byte bit positions
  localparam int CCR_C   = 0;
  localparam int CCR_V   = 1;
  localparam int CCR_Z   = 2;
  localparam int CCR_N   = 3;
  localparam int CCR_IL0 = 4;
  localparam int CCR_IL1 = 5;
  localparam int CCR_I   = 6;
  localparam int CCR_H   = 7;

  // Reset values
  localparam logic [7:0]  CCR_RESET  = 8'h30;
  localparam logic [7:0]  BANK_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [1:0]  IL_BLOCK   = 2'h3;

  // Arithmetic commands
  localparam logic [2:0] OP_ADD8  = 3'h0;
  localparam logic [2:0] OP_SUB8  = 3'h1;
  localparam logic [2:0] OP_ADD16 = 3'h2;
  localparam logic [2:0] OP_SUB16 = 3'h3;
  localparam logic [2:0] OP_SHL8  = 3'h4;
  localparam logic [2:0] OP_SHR8  = 3'h5;
  localparam logic [2:0] OP_AND8  = 3'h6;

  // Memory regions
  localparam logic [1:0] REGION_IO   = 2'h0;
  localparam logic [1:0] REGION_DATA = 2'h1;
  localparam logic [1:0] REGION_GAP  = 2'h2;
  localparam logic [1:0] REGION_PROG = 2'h3;
  localparam logic [15:0] IO_END_DEF    = 16'h007F;
  localparam logic [15:0] DATA_END_DEF  = 16'h7FFF;
  localparam logic [15:0] PROG_BASE_DEF = 16'h8000;
  localparam logic [15:0] GPR_BASE_DEF  = 16'h0100;
endpackage

//--- src/cc_flag_unit.sv
// Purpose: Arithmetic result and condition flags for one command
// Assumes: Purely combinational; the caller latches the outputs
// Notes:   Eight-bit commands leave the high byte of the result unchanged
`timescale 1ns/100ps
module cc_flag_unit (
  input  wire logic [15:0] i_a,
  input  wire logic [15:0] i_t,
  input  wire logic [2:0]  i_op,
  output logic      [15:0] o_res,
  output logic             o_h,
  output logic             o_n,
  output logic             o_z,
  output logic             o_v,
  output logic             o_c,
  output logic             o_upd_h,
  output logic             o_upd_c
);
  logic [8:0]  s8;
  logic [16:0] s16;
  logic [4:0]  s4;

  // Result and flags per command
  always_comb
  begin
    s8      = 9'h000;
    s16     = 17'h0_0000;
    s4      = 5'h00;
    o_res   = i_a;
    o_h     = 1'b0;
    o_v     = 1'b0;
    o_c     = 1'b0;
    o_upd_h = 1'b1;
    o_upd_c = 1'b1;
    case (i_op)
      core_regs_pkg::OP_ADD8, core_regs_pkg::OP_SUB8:
      begin
        if (i_op == core_regs_pkg::OP_ADD8)
        begin
          s8 = {1'b0, i_a[7:0]} + {1'b0, i_t[7:0]};
          s4 = {1'b0, i_a[3:0]} + {1'b0, i_t[3:0]};
          o_v = (i_a[7] == i_t[7]) && (s8[7] != i_a[7]);
        end
        else
        begin
          s8 = {1'b0, i_a[7:0]} - {1'b0, i_t[7:0]};
          s4 = {1'b0, i_a[3:0]} - {1'b0, i_t[3:0]};
          o_v = (i_a[7] != i_t[7]) && (s8[7] != i_a[7]);
        end
        o_res = {i_a[15:8], s8[7:0]};
        o_h   = s4[4];
        o_c   = s8[8];
      end
      core_regs_pkg::OP_ADD16, core_regs_pkg::OP_SUB16:
      begin
        if (i_op == core_regs_pkg::OP_ADD16)
        begin
          s16 = {1'b0, i_a} + {1'b0, i_t};
          s4  = {1'b0, i_a[3:0]} + {1'b0, i_t[3:0]};
          o_v = (i_a[15] == i_t[15]) && (s16[15] != i_a[15]);
        end
        else
        begin
          s16 = {1'b0, i_a} - {1'b0, i_t};
          s4  = {1'b0, i_a[3:0]} - {1'b0, i_t[3:0]};
          o_v = (i_a[15] != i_t[15]) && (s16[15] != i_a[15]);
        end
        o_res = s16[15:0];
        o_h   = s4[4];
        o_c   = s16[16];
      end
      core_regs_pkg::OP_SHL8:
      begin
        o_res   = {i_a[15:8], i_a[6:0], 1'b0};
        o_c     = i_a[7];
        o_upd_h = 1'b0;
      end
      core_regs_pkg::OP_SHR8:
      begin
        o_res   = {i_a[15:8], 1'b0, i_a[7:1]};
        o_c     = i_a[0];
        o_upd_h = 1'b0;
      end
      core_regs_pkg::OP_AND8:
      begin
        o_res   = {i_a[15:8], i_a[7:0] & i_t[7:0]};
        o_upd_h = 1'b0;
        o_upd_c = 1'b0;
      end
      default:
      begin
        o_upd_h = 1'b0;
        o_upd_c = 1'b0;
      end
    endcase
  end

  // Sign and zero follow the width of the command
  always_comb
  begin
    if (i_op == core_regs_pkg::OP_ADD16 || i_op == core_regs_pkg::OP_SUB16)
    begin
      o_n = o_res[15];
      o_z = (o_res == 16'h0000);
    end
    else
    begin
      o_n = o_res[7];
      o_z = (o_res[7:0] == 8'h00);
    end
  end
endmodule

//--- src/bank_map.sv
// Purpose: General register address and memory region decode
// Assumes: Bank number is the low four bits of the bank pointer
// Notes:   Addresses between data end and program base decode as a gap
`timescale 1ns/100ps
module bank_map #(
  parameter logic [15:0] GPR_BASE  = core_regs_pkg::GPR_BASE_DEF,
  parameter logic [15:0] IO_END    = core_regs_pkg::IO_END_DEF,
  parameter logic [15:0] DATA_END  = core_regs_pkg::DATA_END_DEF,
  parameter logic [15:0] PROG_BASE = core_regs_pkg::PROG_BASE_DEF
) (
  input  wire logic [3:0]  i_bank,
  input  wire logic [2:0]  i_index,
  input  wire logic [15:0] i_probe,
  output logic      [15:0] o_gpr_addr,
  output logic      [1:0]  o_region
);
  // Eight registers per bank, banks packed upward from the base
  assign o_gpr_addr = GPR_BASE + {9'h000, i_bank, i_index};

  // I/O lowest, data above it, program at the top
  always_comb
  begin
    if (i_probe <= IO_END)
      o_region = core_regs_pkg::REGION_IO;
    else if (i_probe <= DATA_END)
      o_region = core_regs_pkg::REGION_DATA;
    else if (i_probe >= PROG_BASE)
      o_region = core_regs_pkg::REGION_PROG;
    else
      o_region = core_regs_pkg::REGION_GAP;
  end
endmodule

//--- src/cpu_status_flags_and_banks.sv
// Purpose: Core dedicated registers, condition codes and bank pointer
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   Arithmetic commands act on accumulator and temporary accumulator
//
// Behaviour
// - Sixteen-bit instruction pointer holds fetch address
// - Sixteen-bit accumulator; byte commands use low byte
// - Temporary accumulator is second operand, low byte
// - Index, extra and stack pointers, sixteen bits
// - Status word: bank pointer high, condition low
// - Half carry from bit three into four
// - Interrupt enable allows interrupts; reset clears it
// - Level field gates requests; three blocks all
// - Negative flag copies result top bit
// - Zero flag set on zero result
// - Overflow flag on two's complement overflow
// - Carry from bit seven; shifts take shifted bit
// - Sixteen banks of eight byte registers
// - I/O low, data above, program at top
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module cpu_status_flags_and_banks #(
  parameter logic [15:0] GPR_BASE  = core_regs_pkg::GPR_BASE_DEF,
  parameter logic [15:0] IO_END    = core_regs_pkg::IO_END_DEF,
  parameter logic [15:0] DATA_END  = core_regs_pkg::DATA_END_DEF,
  parameter logic [15:0] PROG_BASE = core_regs_pkg::PROG_BASE_DEF
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic        i_fetch_advance,
  input  wire logic        i_irq_req,
  input  wire logic [1:0]  i_irq_level,
  output logic             o_irq_take,
  output logic      [15:0] o_fetch_addr,
  output logic      [15:0] o_gpr_addr,
  output logic      [1:0]  o_region
);
  logic [15:0] instruction_pointer;
  logic [15:0] accum;
  logic [15:0] temp_accum;
  logic [15:0] index_pointer;
  logic [15:0] extra_pointer;
  logic [15:0] stack_top_pointer;
  logic [7:0]  bank_select_pointer;
  logic [7:0]  condition_code_byte;
  logic [2:0]  gpr_index;
  logic [15:0] probe_addr;
  logic [15:0] program_status_word;
  logic [1:0]  interrupt_level_field;
  logic [15:0] alu_res;
  logic        alu_h;
  logic        alu_n;
  logic        alu_z;
  logic        alu_v;
  logic        alu_c;
  logic        alu_upd_h;
  logic        alu_upd_c;
  logic        alu_go;
  logic [15:0] next_rdata;

  // Write strobe decode used by several processes
  function automatic logic wr_hit(input logic [3:0] off);
    wr_hit = i_wr && (i_addr == off);
  endfunction

  assign alu_go = wr_hit(core_regs_pkg::OFF_ALU_CMD);

  // Status word is bank pointer over condition byte
  assign program_status_word   = {bank_select_pointer, condition_code_byte};
  assign interrupt_level_field = {condition_code_byte[core_regs_pkg::CCR_IL1],
                                  condition_code_byte[core_regs_pkg::CCR_IL0]};

  // Arithmetic on the two accumulators
  cc_flag_unit u_flags (
    .i_a     (accum),
    .i_t     (temp_accum),
    .i_op    (i_wdata[2:0]),
    .o_res   (alu_res),
    .o_h     (alu_h),
    .o_n     (alu_n),
    .o_z     (alu_z),
    .o_v     (alu_v),
    .o_c     (alu_c),
    .o_upd_h (alu_upd_h),
    .o_upd_c (alu_upd_c)
  );

  // Bank addressing and region decode
  bank_map #(
    .GPR_BASE  (GPR_BASE),
    .IO_END    (IO_END),
    .DATA_END  (DATA_END),
    .PROG_BASE (PROG_BASE)
  ) u_map (
    .i_bank     (bank_select_pointer[3:0]),
    .i_index    (gpr_index),
    .i_probe    (probe_addr),
    .o_gpr_addr (o_gpr_addr),
    .o_region   (o_region)
  );

  // Fetch address; a software write wins over the step
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      instruction_pointer <= core_regs_pkg::WORD_RESET;
    else if (wr_hit(core_regs_pkg::OFF_INSTR_PTR))
      instruction_pointer <= i_wdata;
    else if (i_fetch_advance)
      instruction_pointer <= instruction_pointer + 16'h0001;
  end

  assign o_fetch_addr = instruction_pointer;

  // Accumulator takes writes or arithmetic results
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      accum <= core_regs_pkg::WORD_RESET;
    else if (wr_hit(core_regs_pkg::OFF_ACCUM))
      accum <= i_wdata;
    else if (alu_go)
      accum <= alu_res;
  end

  // Second operand register
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      temp_accum <= core_regs_pkg::WORD_RESET;
    else if (wr_hit(core_regs_pkg::OFF_TEMP_ACCUM))
      temp_accum <= i_wdata;
  end

  // Address pointers
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      index_pointer     <= core_regs_pkg::WORD_RESET;
      extra_pointer     <= core_regs_pkg::WORD_RESET;
      stack_top_pointer <= core_regs_pkg::WORD_RESET;
    end
    else
    begin
      if (wr_hit(core_regs_pkg::OFF_INDEX_PTR))
        index_pointer <= i_wdata;
      if (wr_hit(core_regs_pkg::OFF_EXTRA_PTR))
        extra_pointer <= i_wdata;
      if (wr_hit(core_regs_pkg::OFF_STACK_PTR))
        stack_top_pointer <= i_wdata;
    end
  end

  // Bank pointer from the upper half of a status write
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      bank_select_pointer <= core_regs_pkg::BANK_RESET;
    else if (wr_hit(core_regs_pkg::OFF_PSW))
      bank_select_pointer <= i_wdata[15:8];
  end

  // Condition byte: status writes, or flags from a command
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      condition_code_byte <= core_regs_pkg::CCR_RESET;
    else if (wr_hit(core_regs_pkg::OFF_PSW))
      condition_code_byte <= i_wdata[7:0];
    else if (alu_go)
    begin
      condition_code_byte[core_regs_pkg::CCR_N] <= alu_n;
      condition_code_byte[core_regs_pkg::CCR_Z] <= alu_z;
      condition_code_byte[core_regs_pkg::CCR_V] <= alu_v;
      if (alu_upd_h)
        condition_code_byte[core_regs_pkg::CCR_H] <= alu_h;
      if (alu_upd_c)
        condition_code_byte[core_regs_pkg::CCR_C] <= alu_c;
    end
  end

  // Register select and probe address
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      gpr_index  <= 3'h0;
      probe_addr <= core_regs_pkg::WORD_RESET;
    end
    else
    begin
      if (wr_hit(core_regs_pkg::OFF_GPR_SEL))
        gpr_index <= i_wdata[2:0];
      if (wr_hit(core_regs_pkg::OFF_PROBE))
        probe_addr <= i_wdata;
    end
  end

  // Request taken only if enabled, field not at the blocking level, and of higher priority
  assign o_irq_take = i_irq_req
                   && condition_code_byte[core_regs_pkg::CCR_I]
                   && (interrupt_level_field != core_regs_pkg::IL_BLOCK)
                   && (i_irq_level < interrupt_level_field);

  // Read mux; unmapped indices read as zero
  always_comb
  begin
    case (i_addr)
      core_regs_pkg::OFF_INSTR_PTR:  next_rdata = instruction_pointer;
      core_regs_pkg::OFF_ACCUM:      next_rdata = accum;
      core_regs_pkg::OFF_TEMP_ACCUM: next_rdata = temp_accum;
      core_regs_pkg::OFF_INDEX_PTR:  next_rdata = index_pointer;
      core_regs_pkg::OFF_EXTRA_PTR:  next_rdata = extra_pointer;
      core_regs_pkg::OFF_STACK_PTR:  next_rdata = stack_top_pointer;
      core_regs_pkg::OFF_PSW:        next_rdata = program_status_word;
      core_regs_pkg::OFF_GPR_SEL:    next_rdata = {13'h0000, gpr_index};
      core_regs_pkg::OFF_GPR_ADDR:   next_rdata = o_gpr_addr;
      core_regs_pkg::OFF_PROBE:      next_rdata = probe_addr;
      core_regs_pkg::OFF_REGION:     next_rdata = {14'h0000, o_region};
      default:                       next_rdata = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= 16'h0000;
    else if (i_rd)
      o_rdata <= next_rdata;
    else
      o_rdata <= 16'h0000;
  end

  // Stepping advances the fetch address by one
  ip_step_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_fetch_advance && !i_wr) |=> (o_fetch_addr == $past(o_fetch_addr) + 16'h0001))
    else $error("fetch address did not step");

  // Byte commands keep the accumulator high byte
  acc_high_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (alu_go && i_wdata[2:0] != core_regs_pkg::OP_ADD16
            && i_wdata[2:0] != core_regs_pkg::OP_SUB16)
      |=> (accum[15:8] == $past(accum[15:8])))
    else $error("byte command changed high byte");

  // Status word read shows bank pointer over condition byte
  psw_read_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_rd && i_addr == core_regs_pkg::OFF_PSW)
      |=> (o_rdata == {$past(bank_select_pointer), $past(condition_code_byte)}))
    else $error("status word read mismatch");

  // Zero flag tracks a byte result
  zero_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (alu_go && i_wdata[2:0] == core_regs_pkg::OP_ADD8)
      |=> (condition_code_byte[core_regs_pkg::CCR_Z] == (accum[7:0] == 8'h00)))
    else $error("zero flag wrong");

  // Negative flag copies the result top bit
  neg_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (alu_go && i_wdata[2:0] == core_regs_pkg::OP_SUB8)
      |=> (condition_code_byte[core_regs_pkg::CCR_N] == accum[7]))
    else $error("negative flag wrong");

  // Left shift carries out the old bit seven
  shift_carry_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (alu_go && i_wdata[2:0] == core_regs_pkg::OP_SHL8)
      |=> (condition_code_byte[core_regs_pkg::CCR_C] == $past(accum[7])))
    else $error("shift carry wrong");

  // Interrupt only when enabled and level permits
  irq_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_irq_take |-> (condition_code_byte[core_regs_pkg::CCR_I]
                    && interrupt_level_field != core_regs_pkg::IL_BLOCK))
    else $error("interrupt taken while gated");

  // Register address follows bank and index
  gpr_addr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_hit(core_regs_pkg::OFF_GPR_SEL)
      |=> (o_gpr_addr == GPR_BASE + {9'h000, bank_select_pointer[3:0], $past(i_wdata[2:0])}))
    else $error("register address mismatch");

  // Low addresses decode as I/O
  io_region_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (probe_addr <= IO_END) |-> (o_region == core_regs_pkg::REGION_IO))
    else $error("low address not I/O");

  // Reads without a strobe leave the data bus at zero
  rdata_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !i_rd |=> (o_rdata == 16'h0000))
    else $error("read data outside its cycle");

  // A software write lands in the fetch address
  ip_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_hit(core_regs_pkg::OFF_INSTR_PTR) |=> (o_fetch_addr == $past(i_wdata)))
    else $error("fetch address write lost");

  // Second operand takes its write
  temp_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_hit(core_regs_pkg::OFF_TEMP_ACCUM) |=> (temp_accum == $past(i_wdata)))
    else $error("second operand write lost");

  // Stack pointer keeps a full word
  stack_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_hit(core_regs_pkg::OFF_STACK_PTR) |=> (stack_top_pointer == $past(i_wdata)))
    else $error("stack pointer write lost");

  // Bank pointer takes the upper half of a status write
  bank_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_hit(core_regs_pkg::OFF_PSW) |=> (bank_select_pointer == $past(i_wdata[15:8])))
    else $error("bank pointer write lost");

  // Half carry on a byte add from bit three into four
  half_carry_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (alu_go && i_wdata[2:0] == core_regs_pkg::OP_ADD8)
      |=> (condition_code_byte[core_regs_pkg::CCR_H]
           == (({1'b0, $past(accum[3:0])} + {1'b0, $past(temp_accum[3:0])}) > 5'h0F)))
    else $error("half carry wrong");

  // Byte add overflows when like signs give an unlike sign
  byte_ovf_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (alu_go && i_wdata[2:0] == core_regs_pkg::OP_ADD8)
      |=> (condition_code_byte[core_regs_pkg::CCR_V]
           == (($past(accum[7]) == $past(temp_accum[7])) && (accum[7] != $past(accum[7])))))
    else $error("overflow flag wrong");

  // Byte add carries out of bit seven
  add_carry_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (alu_go && i_wdata[2:0] == core_regs_pkg::OP_ADD8)
      |=> (condition_code_byte[core_regs_pkg::CCR_C]
           == (({1'b0, $past(accum[7:0])} + {1'b0, $past(temp_accum[7:0])}) > 9'h0FF)))
    else $error("add carry wrong");

  // Byte subtract borrows when the subtrahend is larger
  sub_borrow_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (alu_go && i_wdata[2:0] == core_regs_pkg::OP_SUB8)
      |=> (condition_code_byte[core_regs_pkg::CCR_C]
           == ($past(accum[7:0]) < $past(temp_accum[7:0]))))
    else $error("subtract borrow wrong");

  // Addresses from the program base up decode as program
  prog_region_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (probe_addr >= PROG_BASE) |-> (o_region == core_regs_pkg::REGION_PROG))
    else $error("high address not program");
endmodule

//--- verif/cpu_status_flags_and_banks_tb.sv
// Purpose: Self-checking bench for the core register, flag and bank block
// Assumes: Register port with read data standing only in the cycle after the strobe
// Notes:   Data end is lowered so that the gap below the program area decodes
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module cpu_status_flags_and_banks_tb;
  localparam logic [15:0] IO_E   = 16'h007F;
  localparam logic [15:0] DATA_E = 16'h5FFF;
  localparam logic [15:0] PROG_B = 16'h8000;
  localparam logic [15:0] GPR_B  = 16'h0100;

  typedef struct packed
  {
    logic [2:0]  op;
    logic [15:0] a;
    logic [15:0] t;
    logic [15:0] psw;
    logic [15:0] exp_a;
    logic [15:0] exp_psw;
  } alu_row_t;

  // Command, operands and preset status word beside the expected outcome
  alu_row_t    rows [13] = '{
    '{core_regs_pkg::OP_ADD8,  16'h1208, 16'h0008, 16'h0C8F, 16'h1210, 16'h0C80},
    '{core_regs_pkg::OP_ADD8,  16'h00FF, 16'h0001, 16'h0030, 16'h0000, 16'h00B5},
    '{core_regs_pkg::OP_ADD8,  16'h007F, 16'h0001, 16'h0030, 16'h0080, 16'h00BA},
    '{core_regs_pkg::OP_SUB8,  16'h0055, 16'h0055, 16'h00BF, 16'h0000, 16'h0034},
    '{core_regs_pkg::OP_SUB8,  16'h0000, 16'h0001, 16'h0030, 16'h00FF, 16'h00B9},
    '{core_regs_pkg::OP_SUB8,  16'h0080, 16'h0001, 16'h0030, 16'h007F, 16'h00B2},
    '{core_regs_pkg::OP_ADD16, 16'hFFFF, 16'h0001, 16'h0030, 16'h0000, 16'h00B5},
    '{core_regs_pkg::OP_ADD16, 16'h7FFF, 16'h0001, 16'h0030, 16'h8000, 16'h00BA},
    '{core_regs_pkg::OP_SUB16, 16'h0000, 16'h0001, 16'h0030, 16'hFFFF, 16'h00B9},
    '{core_regs_pkg::OP_SHL8,  16'h1281, 16'h0000, 16'h00B0, 16'h1202, 16'h00B1},
    '{core_regs_pkg::OP_SHR8,  16'h0001, 16'h0000, 16'h0030, 16'h0000, 16'h0035},
    '{core_regs_pkg::OP_AND8,  16'h00F0, 16'h0080, 16'h0081, 16'h0080, 16'h0089},
    '{3'h7,                    16'h1234, 16'h0000, 16'h00BF, 16'h1234, 16'h00B1}
  };
  // Probe addresses on both sides of every region limit
  logic [15:0] probe [8] = '{16'h0000, IO_E, IO_E + 16'h0001, DATA_E,
                             DATA_E + 16'h0001, PROG_B - 16'h0001, PROG_B, 16'hFFFF};

  logic        i_clk_sys       = 1'b0;
  logic        i_rst           = 1'b1;
  logic [3:0]  i_addr          = 4'h0;
  logic [15:0] i_wdata         = 16'h0000;
  logic        i_wr            = 1'b0;
  logic        i_rd            = 1'b0;
  logic        i_fetch_advance = 1'b0;
  logic        i_irq_req       = 1'b0;
  logic [1:0]  i_irq_level     = 2'h0;
  logic [15:0] o_rdata;
  logic        o_irq_take;
  logic [15:0] o_fetch_addr;
  logic [15:0] o_gpr_addr;
  logic [1:0]  o_region;
  int          error_cnt       = 0;
  int          n_checks        = 0;

  cpu_status_flags_and_banks #(
    .GPR_BASE  (GPR_B),
    .IO_END    (IO_E),
    .DATA_END  (DATA_E),
    .PROG_BASE (PROG_B)
  ) DUT (
    .i_clk_sys       (i_clk_sys),
    .i_rst           (i_rst),
    .i_addr          (i_addr),
    .i_wdata         (i_wdata),
    .i_wr            (i_wr),
    .i_rd            (i_rd),
    .o_rdata         (o_rdata),
    .i_fetch_advance (i_fetch_advance),
    .i_irq_req       (i_irq_req),
    .i_irq_level     (i_irq_level),
    .o_irq_take      (o_irq_take),
    .o_fetch_addr    (o_fetch_addr),
    .o_gpr_addr      (o_gpr_addr),
    .o_region        (o_region)
  );

  // 40 MHz system clock
  always #12.5 i_clk_sys = ~i_clk_sys;

  // One write cycle on the register port
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask

  // One read cycle; the answer is looked at in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, exp)
  endtask

  // Verdict and end of run
  task automatic summarize;
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial
  begin
    repeat (5000) @(posedge i_clk_sys);
    error_cnt++;
    $display("wrong value at %0t: sequence did not finish", $time);
    summarize();
  end

  // Main sequence
  initial
  begin
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1;
    `CHK(o_fetch_addr, 16'h0000)
    `CHK(o_irq_take, 1'b0)
    `CHK(o_gpr_addr, GPR_B)
    `CHK(o_region, core_regs_pkg::REGION_IO)
    for (int i = 0; i < 6; i++)
      rd_chk(4'(i), 16'h0000);
    rd_chk(core_regs_pkg::OFF_PSW, 16'h0030);
    // Arithmetic commands from the table
    foreach (rows[k])
    begin
      wr(core_regs_pkg::OFF_ACCUM, rows[k].a);
      wr(core_regs_pkg::OFF_TEMP_ACCUM, rows[k].t);
      wr(core_regs_pkg::OFF_PSW, rows[k].psw);
      wr(core_regs_pkg::OFF_ALU_CMD, {13'h0000, rows[k].op});
      rd_chk(core_regs_pkg::OFF_ACCUM, rows[k].exp_a);
      rd_chk(core_regs_pkg::OFF_PSW, rows[k].exp_psw);
    end
    // Full sixteen-bit words in the six registers from instruction pointer to stack pointer
    for (int i = 0; i < 6; i++)
    begin
      wr(4'(i), 16'hA5C3 ^ 16'(i * 16'h1111));
      rd_chk(4'(i), 16'hA5C3 ^ 16'(i * 16'h1111));
    end
    // Fetch address wraps past the top, and a write beats an advance
    wr(core_regs_pkg::OFF_INSTR_PTR, 16'hFFFE);
    i_fetch_advance <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    i_fetch_advance <= 1'b0;
    #1;
    `CHK(o_fetch_addr, 16'h0001)
    @(posedge i_clk_sys);
    i_fetch_advance <= 1'b1;
    i_wr            <= 1'b1;
    i_addr          <= core_regs_pkg::OFF_INSTR_PTR;
    i_wdata         <= 16'h4000;
    @(posedge i_clk_sys);
    i_fetch_advance <= 1'b0;
    i_wr            <= 1'b0;
    #1;
    `CHK(o_fetch_addr, 16'h4000)
    // Every bank, with junk in the unused upper bank pointer bits
    for (int b = 0; b < 16; b++)
    begin
      wr(core_regs_pkg::OFF_GPR_SEL, 16'(b % 8));
      wr(core_regs_pkg::OFF_PSW, {4'(15 - b), 4'(b), 8'h30});
      `CHK(o_gpr_addr, GPR_B + 16'(b * 8 + b % 8))
    end
    rd_chk(core_regs_pkg::OFF_PSW, 16'h0F30);
    wr(core_regs_pkg::OFF_GPR_ADDR, 16'hFFFF);
    rd_chk(core_regs_pkg::OFF_GPR_ADDR, GPR_B + 16'h007F);
    wr(4'hC, 16'hFFFF);
    rd_chk(4'hC, 16'h0000);
    // Regions: two probes per region in rising order
    for (int k = 0; k < 8; k++)
    begin
      wr(core_regs_pkg::OFF_PROBE, probe[k]);
      `CHK(o_region, 2'(k / 2))
      rd_chk(core_regs_pkg::OFF_REGION, 16'(k / 2));
    end
    // Vector tables live at the very top, which must decode as program
    wr(core_regs_pkg::OFF_PROBE, 16'hFFF0);
    `CHK(o_region, core_regs_pkg::REGION_PROG)
    // Interrupt gate over enable, level field, request and request level
    for (int e = 0; e < 2; e++)
      for (int il = 0; il < 4; il++)
      begin
        wr(core_regs_pkg::OFF_PSW, {8'h00, 1'b0, 1'(e), 2'(il), 4'h0});
        for (int r = 0; r < 8; r++)
        begin
          @(posedge i_clk_sys);
          i_irq_req   <= r[2];
          i_irq_level <= r[1:0];
          #1;
          `CHK(o_irq_take, r[2] & (e == 1) & (r[1:0] < il) & (il != 3))
        end
      end
    // Reset in mid-run with interrupts enabled and a request pending
    wr(core_regs_pkg::OFF_PSW, 16'h0360);
    @(posedge i_clk_sys);
    i_irq_level <= 2'h0;
    i_irq_req   <= 1'b1;
    #1;
    `CHK(o_irq_take, 1'b1)
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    #1;
    `CHK(o_irq_take, 1'b0)
    `CHK(o_fetch_addr, 16'h0000)
    @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd_chk(core_regs_pkg::OFF_PSW, 16'h0030);
    @(posedge i_clk_sys);
    #1;
    `CHK(o_rdata, 16'h0000)
    `CHK(o_gpr_addr, GPR_B)
    summarize();
  end
endmodule
